// file: core/adc_seq_defs.svh
// constants for the converter sequence and flag control block
// assumes an 8-bit register port and a 200 MHz sys_clk
//
// Overview of operation
// - software picks single or continuous runs on one channel or a channel sequence
// - entering stop mode aborts a running sequence; leaving it restarts that sequence
// - the stop-mode restart acts like a start register write, clearing all flags
// - run and wait modes behave the same; conversions carry on while the cpu waits
// - in debug freeze the two freeze bits pick continue, finish current, or stop
// - done flag n is set when conversion at sequence position n ends
// - with compare on for n, flag n sets only on a true compare; result dropped
// - compare irq enable with a compare-qualified flag set requests a compare interrupt
// - any write to the sequence start register clears every done flag
// - fast clear off: writing one to a flag bit clears it, zero leaves it
// - fast clear on, compare off for n: reading result n clears flag n
// - fast clear on, compare on for n: writing result n clears flag n
// - start clear beats a coincident set; other clears lose to the set
// - resolution is selectable as 8, 10 or 12 bits
// - the engine finds the result by successive approximation binary search
// - the engine is powered down whenever no conversion is running
// - the input mux routes exactly one of eight channels per conversion
// - sample phase connects the input to the storage node; hold disconnects it
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define ADC_OFS_CONFIG 8'h02
`define ADC_OFS_SEQ_LEN 8'h03
`define ADC_OFS_START 8'h05
`define ADC_OFS_BUSY 8'h06
`define ADC_OFS_CMP_EN 8'h08
`define ADC_OFS_CMP_GT 8'h09
`define ADC_OFS_DONE 8'h0a
`define ADC_OFS_RESULT 8'h10
`define ADC_OFS_RESULT_END 8'h1f

// config register fields
`define ADC_CFG_RES_LSB 0
`define ADC_CFG_FFC_BIT 2
`define ADC_CFG_CIRQ_BIT 3
`define ADC_CFG_FRZ_LSB 4
// start register fields
`define ADC_START_SCAN_BIT 0
`define ADC_START_MULT_BIT 1
`define ADC_START_CH_LSB 2

`define ADC_RST_CONFIG 8'h00
`define ADC_RST_SEQ_LEN 3'h0
`define ADC_RST_CMP 8'h00

`define ADC_CLK_NS 5
`define ADC_SAMPLE_NS 20
`define ADC_SAMPLE_CYC ((`ADC_SAMPLE_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`endif

// file: core/adc_seq_pkg.sv
// types shared by the converter sequence and flag control block
// assumes the constants header for field widths
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11,
        ST_DONE = 2'b10
    } conv_state_e;

    typedef enum logic [1:0] {
        FRZ_CONTINUE = 2'b00,
        FRZ_FINISH = 2'b01,
        FRZ_STOP = 2'b10,
        FRZ_STOP_ALT = 2'b11
    } freeze_sel_e;

    typedef struct packed {
        conv_state_e st;
        logic [2:0] pos;
        logic [2:0] ch;
        logic [3:0] cnt;
        logic [3:0] bitn;
        logic [11:0] sar;
        logic [7:0] flags;
        logic [1:0] res;
        logic ffc;
        logic cirq;
        logic [1:0] frz;
        logic [2:0] len;
        logic scan;
        logic mult;
        logic [2:0] chan;
        logic [7:0] compare_enable_bits;
        logic [7:0] compare_greater_sel;
        logic aborted;
        logic stop_d;
        logic [7:0] rreg;
        logic rmem;
        logic rhi;
    } ctl_s;

endpackage

// file: core/result_mem.sv
// result and compare value store, one write port with bit mask, two read ports
// assumes the owner never needs read data before the cycle after the address
`timescale 1ns/1ps
module result_mem #(
    parameter int W = 12,
    parameter int D = 8,
    parameter int AW = 3
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [W-1:0] wmask,
    input wire logic [AW-1:0] raddr_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [W-1:0] rdata_a,
    output logic [W-1:0] rdata_b
);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [W-1:0] ra;
        logic [W-1:0] rb;
    } mem_s;

    mem_s m_ff;
    mem_s nxt_m;

    always_comb begin
        nxt_m = m_ff;
        nxt_m.ra = m_ff.mem[raddr_a];
        nxt_m.rb = m_ff.mem[raddr_b];
        if (we) begin
            nxt_m.mem[waddr] = (m_ff.mem[waddr] & ~wmask) | (wdata & wmask);
        end
    end

    // no reset: contents are undefined until software or a conversion writes them
    always_ff @(posedge sys_clk) begin
        m_ff <= nxt_m;
    end

    assign rdata_a = m_ff.ra;
    assign rdata_b = m_ff.rb;

endmodule

// file: core/adc_sequence_flag_control.sv
// sequencing, successive approximation engine and done-flag logic of the converter
// assumes synchronous mode inputs and a comparator that answers dac_code in the same cycle
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_sequence_flag_control #(
    parameter int SAMPLE_CYC = `ADC_SAMPLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic stop_mode,
    input wire logic freeze_mode,
    input wire logic comp_in,
    output logic [2:0] mux_sel,
    output logic sample_en,
    output logic sar_power_en,
    output logic [11:0] dac_code,
    output logic busy,
    output logic cmp_irq
);

    adc_seq_pkg::ctl_s s_ff;
    adc_seq_pkg::ctl_s nxt_s;

    logic wr_start;
    logic wr_done;
    logic wr_res;
    logic rd_res;
    logic res_sel_hi;
    logic [2:0] res_idx;
    logic restart;
    logic start_any;
    logic frozen_hold;
    logic finish_hold;
    logic last_bit;
    logic cmp_true;
    logic conv_end;
    logic store_conv;
    logic [3:0] low_bit;
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [7:0] pos_oh;
    logic [11:0] mem_a;
    logic [11:0] mem_b;
    logic [11:0] mem_wdata;
    logic [11:0] mem_wmask;
    logic mem_we;

    assign wr_start = wr && addr == `ADC_OFS_START;
    assign wr_done = wr && addr == `ADC_OFS_DONE;
    assign res_sel_hi = ~addr[0];
    assign res_idx = addr[3:1];
    assign wr_res = wr && addr >= `ADC_OFS_RESULT && addr <= `ADC_OFS_RESULT_END;
    assign rd_res = rd && addr >= `ADC_OFS_RESULT && addr <= `ADC_OFS_RESULT_END;

    assign restart = !stop_mode && s_ff.stop_d && s_ff.aborted;
    assign start_any = wr_start || restart;

    // finish-current holds only between conversions, stop holds every state
    assign finish_hold = freeze_mode && s_ff.frz == adc_seq_pkg::FRZ_FINISH;
    assign frozen_hold = freeze_mode && s_ff.frz[1];

    // lowest trial bit: 8 bits stops at 4, 10 at 2, 12 at 0
    assign low_bit = s_ff.res[1] ? 4'h0 : (s_ff.res[0] ? 4'h2 : 4'h4);
    assign last_bit = s_ff.bitn == low_bit;

    assign cmp_true = s_ff.compare_greater_sel[s_ff.pos] ? (s_ff.sar > mem_b) : (s_ff.sar <= mem_b);
    assign conv_end = s_ff.st == adc_seq_pkg::ST_DONE;
    assign store_conv = conv_end && !s_ff.compare_enable_bits[s_ff.pos];

    // conversion store takes the port; a coincident software result write is dropped
    assign mem_we = store_conv || wr_res;
    assign mem_wdata = store_conv ? s_ff.sar : {wdata[3:0], wdata};
    assign mem_wmask = store_conv ? 12'hfff : (res_sel_hi ? 12'hf00 : 12'h0ff);

    result_mem #(
        .W(12),
        .D(8),
        .AW(3)
    ) u_mem (
        .sys_clk(sys_clk),
        .we(mem_we),
        .waddr(store_conv ? s_ff.pos : res_idx),
        .wdata(mem_wdata),
        .wmask(mem_wmask),
        .raddr_a(res_idx),
        .raddr_b(s_ff.pos),
        .rdata_a(mem_a),
        .rdata_b(mem_b)
    );

    genvar n;
    generate
        for (n = 0; n < 8; n++) begin : g_flag
            assign pos_oh[n] = s_ff.pos == 3'(n);
            assign set_v[n] = conv_end && pos_oh[n] && (!s_ff.compare_enable_bits[n] || cmp_true);
            assign clr_v[n] = (!s_ff.ffc && wr_done && wdata[n])
                || (s_ff.ffc && !s_ff.compare_enable_bits[n] && rd_res && res_idx == 3'(n))
                || (s_ff.ffc && s_ff.compare_enable_bits[n] && wr_res && res_idx == 3'(n));
        end
    endgenerate

    always_comb begin
        nxt_s = s_ff;
        nxt_s.stop_d = stop_mode;
        // start clear first, then set beats the software clears
        nxt_s.flags = start_any ? 8'h00 : ((s_ff.flags & ~clr_v) | set_v);

        if (wr) begin
            case (addr)
                `ADC_OFS_CONFIG: begin
                    nxt_s.res = wdata[`ADC_CFG_RES_LSB +: 2];
                    nxt_s.ffc = wdata[`ADC_CFG_FFC_BIT];
                    nxt_s.cirq = wdata[`ADC_CFG_CIRQ_BIT];
                    nxt_s.frz = wdata[`ADC_CFG_FRZ_LSB +: 2];
                end
                `ADC_OFS_SEQ_LEN: nxt_s.len = wdata[2:0];
                `ADC_OFS_START: begin
                    nxt_s.scan = wdata[`ADC_START_SCAN_BIT];
                    nxt_s.mult = wdata[`ADC_START_MULT_BIT];
                    nxt_s.chan = wdata[`ADC_START_CH_LSB +: 3];
                end
                `ADC_OFS_CMP_EN: nxt_s.compare_enable_bits = wdata;
                `ADC_OFS_CMP_GT: nxt_s.compare_greater_sel = wdata;
                default: ;
            endcase
        end

        nxt_s.rmem = rd_res;
        nxt_s.rhi = res_sel_hi;
        case (addr)
            `ADC_OFS_CONFIG: nxt_s.rreg = {2'h0, s_ff.frz, s_ff.cirq, s_ff.ffc, s_ff.res};
            `ADC_OFS_SEQ_LEN: nxt_s.rreg = {5'h00, s_ff.len};
            `ADC_OFS_START: nxt_s.rreg = {3'h0, s_ff.chan, s_ff.mult, s_ff.scan};
            `ADC_OFS_BUSY: begin
                nxt_s.rreg = {3'h0, s_ff.pos, s_ff.aborted, s_ff.st != adc_seq_pkg::ST_IDLE};
            end
            `ADC_OFS_CMP_EN: nxt_s.rreg = s_ff.compare_enable_bits;
            `ADC_OFS_CMP_GT: nxt_s.rreg = s_ff.compare_greater_sel;
            `ADC_OFS_DONE: nxt_s.rreg = s_ff.flags;
            default: nxt_s.rreg = 8'h00;
        endcase

        // wait mode has no input here: the engine runs regardless of it
        case (s_ff.st)
            adc_seq_pkg::ST_IDLE: ;
            adc_seq_pkg::ST_SAMPLE: begin
                if (!(frozen_hold || (finish_hold && s_ff.cnt == 4'h0))) begin
                    if (s_ff.cnt == 4'(SAMPLE_CYC - 1)) begin
                        nxt_s.st = adc_seq_pkg::ST_CONVERT;
                        nxt_s.cnt = 4'h0;
                        nxt_s.bitn = 4'hb;
                        nxt_s.sar = 12'h800;
                    end else begin
                        nxt_s.cnt = s_ff.cnt + 4'h1;
                    end
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                if (!frozen_hold) begin
                    // keep the trial bit when the sample is at or above the trial level
                    if (!comp_in) begin
                        nxt_s.sar[s_ff.bitn] = 1'b0;
                    end
                    if (last_bit) begin
                        nxt_s.st = adc_seq_pkg::ST_DONE;
                    end else begin
                        nxt_s.bitn = s_ff.bitn - 4'h1;
                        nxt_s.sar[s_ff.bitn - 4'h1] = 1'b1;
                    end
                end
            end
            adc_seq_pkg::ST_DONE: begin
                // freeze stop also parks the done step, so the position waits; the flag still sets on entering it
                if (!frozen_hold) begin
                    if (s_ff.pos == s_ff.len) begin
                        nxt_s.pos = 3'h0;
                        nxt_s.st = s_ff.scan ? adc_seq_pkg::ST_SAMPLE : adc_seq_pkg::ST_IDLE;
                    end else begin
                        nxt_s.pos = s_ff.pos + 3'h1;
                        nxt_s.st = adc_seq_pkg::ST_SAMPLE;
                    end
                    nxt_s.ch = s_ff.mult ? s_ff.chan + nxt_s.pos : s_ff.chan;
                    nxt_s.cnt = 4'h0;
                end
            end
            default: nxt_s.st = adc_seq_pkg::ST_IDLE;
        endcase

        if (start_any) begin
            nxt_s.st = adc_seq_pkg::ST_SAMPLE;
            nxt_s.pos = 3'h0;
            nxt_s.cnt = 4'h0;
            nxt_s.aborted = 1'b0;
            nxt_s.ch = wr_start ? wdata[`ADC_START_CH_LSB +: 3] : s_ff.chan;
        end
        if (stop_mode && s_ff.st != adc_seq_pkg::ST_IDLE) begin
            nxt_s.st = adc_seq_pkg::ST_IDLE;
            nxt_s.aborted = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rdata = s_ff.rmem ? (s_ff.rhi ? {4'h0, mem_a[11:8]} : mem_a[7:0]) : s_ff.rreg;
    assign mux_sel = s_ff.ch;
    assign sample_en = s_ff.st == adc_seq_pkg::ST_SAMPLE;
    assign sar_power_en = s_ff.st == adc_seq_pkg::ST_CONVERT;
    assign dac_code = s_ff.sar;
    assign busy = s_ff.st != adc_seq_pkg::ST_IDLE;
    // level request: stays while any compare-qualified flag stands
    assign cmp_irq = s_ff.cirq && |(s_ff.flags & s_ff.compare_enable_bits);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    property p_start_clear;
        wr_start |=> s_ff.flags == 8'h00;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start write left a flag set");

    property p_set_done;
        (conv_end && !s_ff.compare_enable_bits[s_ff.pos] && !start_any) |=> (s_ff.flags & $past(pos_oh)) != 8'h00;
    endproperty
    a_set_done: assert property (p_set_done) else $error("done flag not set at conversion end");

    property p_w1c;
        (!s_ff.ffc && wr_done && !start_any && set_v == 8'h00) |=> (s_ff.flags & $past(wdata)) == 8'h00;
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

    property p_set_wins;
        (conv_end && !start_any && set_v != 8'h00 && clr_v == set_v) |=> (s_ff.flags & $past(set_v)) == $past(set_v);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a coincident set");

    property p_power;
        !busy |-> !sar_power_en && !sample_en;
    endproperty
    a_power: assert property (p_power) else $error("engine powered while idle");

    property p_abort;
        (stop_mode && busy) |=> !busy && s_ff.aborted;
    endproperty
    a_abort: assert property (p_abort) else $error("stop mode did not abort");

    property p_restart;
        ($fell(stop_mode) && s_ff.aborted) |-> ##1 (sample_en && s_ff.flags == 8'h00 && s_ff.pos == 3'h0);
    endproperty
    a_restart: assert property (p_restart) else $error("no restart after stop mode");

    property p_irq;
        (conv_end && s_ff.compare_enable_bits[s_ff.pos] && cmp_true && s_ff.cirq && !start_any && !wr) |=> cmp_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("compare interrupt missing");

    property p_freeze;
        (freeze_mode && s_ff.frz[1] && !stop_mode && !start_any && !wr) |=> $stable(s_ff.st) && $stable(s_ff.sar);
    endproperty
    a_freeze: assert property (p_freeze) else $error("engine moved under freeze stop");

    property p_reset_flags;
        $rose(rstn) |-> s_ff.flags == 8'h00;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("flag set out of reset");

    property p_fast_rd;
        (s_ff.ffc && rd_res && !s_ff.compare_enable_bits[res_idx] && !set_v[res_idx] && !start_any)
        |=> !s_ff.flags[$past(res_idx)];
    endproperty
    a_fast_rd: assert property (p_fast_rd) else $error("result read did not clear flag");

    property p_fast_wr;
        (s_ff.ffc && wr_res && s_ff.compare_enable_bits[res_idx] && !set_v[res_idx])
        |=> !s_ff.flags[$past(res_idx)];
    endproperty
    a_fast_wr: assert property (p_fast_wr) else $error("result write did not clear flag");

    property p_w0_keep;
        (!s_ff.ffc && wr_done && !start_any)
        |=> ((s_ff.flags ^ $past(s_ff.flags)) & ~$past(wdata) & ~$past(set_v)) == 8'h00;
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("write zero changed a flag");

    property p_mux_mult;
        (conv_end && s_ff.mult && !start_any && !frozen_hold)
        |=> mux_sel == 3'(s_ff.chan + s_ff.pos);
    endproperty
    a_mux_mult: assert property (p_mux_mult) else $error("wrong channel for position");

    property p_sample_end;
        (sample_en && !frozen_hold && !finish_hold && !start_any && !stop_mode && s_ff.cnt == 4'(SAMPLE_CYC - 1))
        |=> sar_power_en && dac_code == 12'h800;
    endproperty
    a_sample_end: assert property (p_sample_end) else $error("search did not start at mid code");

    property p_res8;
        (conv_end && s_ff.res == 2'h0 && !s_ff.compare_enable_bits[s_ff.pos])
        |-> s_ff.sar[3:0] == 4'h0;
    endproperty
    a_res8: assert property (p_res8) else $error("8-bit result has low bits set");

    property p_finish;
        (freeze_mode && s_ff.frz == adc_seq_pkg::FRZ_FINISH && sample_en && s_ff.cnt == 4'h0 && !start_any && !stop_mode)
        |=> sample_en && s_ff.cnt == 4'h0;
    endproperty
    a_finish: assert property (p_finish) else $error("next sample began under freeze finish");

    property p_scan_wrap;
        (conv_end && s_ff.scan && s_ff.pos == s_ff.len && !start_any && !stop_mode && !frozen_hold)
        |=> sample_en && s_ff.pos == 3'h0;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap) else $error("continuous run did not wrap");

    property p_single_end;
        (conv_end && !s_ff.scan && s_ff.pos == s_ff.len && !start_any && !frozen_hold)
        |=> !busy;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single run did not stop");

    property p_rd_done;
        (rd && addr == `ADC_OFS_DONE)
        |=> rdata == $past(s_ff.flags);
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("flag read returned wrong data");

    c_restart: cover property ($fell(stop_mode) && s_ff.aborted);
    c_freeze_hold: cover property (frozen_hold && sar_power_en);
    c_fast_clear: cover property (s_ff.ffc && rd_res);
    c_cmp_set: cover property (conv_end && s_ff.compare_enable_bits[s_ff.pos] && cmp_true);
    c_wrap: cover property (conv_end && s_ff.scan && s_ff.pos == s_ff.len);

endmodule

// file: tb/analog_src.sv
// analog source model: eight channel levels, sample and hold, comparator
// assumes mux_sel, sample_en and dac_code come from sys_clk flops of the converter
`timescale 1ns/1ps
module analog_src (
    input wire logic sys_clk,
    input wire logic [11:0] lvl [8],
    input wire logic [2:0] mux_sel,
    input wire logic sample_en,
    input wire logic [11:0] dac_code,
    output logic comp_in
);
    logic [11:0] held;
    // storage node follows the routed input only while sampling, so hold keeps it
    always_ff @(posedge sys_clk) if (sample_en) held <= lvl[mux_sel];
    assign comp_in = held >= dac_code;
endmodule

// file: tb/adc_sequence_flag_control_tb.sv
// self-checking bench for the converter sequence and flag control block
// assumes the analog source model on the far side and left-aligned 12-bit results
`timescale 1ns/1ps
module adc_sequence_flag_control_tb;
    logic sys_clk, rstn, wr, rd, stop_mode, freeze_mode, comp_in, sample_en, sar_power_en, busy, cmp_irq;
    logic [7:0] addr, wdata, rdata, v;
    logic [2:0] mux_sel, c;
    logic [11:0] dac_code, r, q;
    logic [11:0] lvl [8];
    logic [31:0] seed = 32'h4ecd0d09;
    int bad_count = 0;
    int total_checks = 0;

    adc_sequence_flag_control #(.SAMPLE_CYC(4)) DUT (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stop_mode(stop_mode), .freeze_mode(freeze_mode),
        .comp_in(comp_in), .mux_sel(mux_sel), .sample_en(sample_en), .sar_power_en(sar_power_en),
        .dac_code(dac_code), .busy(busy), .cmp_irq(cmp_irq));
    analog_src src (.sys_clk(sys_clk), .lvl(lvl), .mux_sel(mux_sel), .sample_en(sample_en),
        .dac_code(dac_code), .comp_in(comp_in));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] quant(input logic [11:0] h, input logic [1:0] res);
        return res == 2'h0 ? {h[11:4], 4'h0} : res == 2'h1 ? {h[11:2], 2'h0} : h;
    endfunction

    task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rd_res(input int n, output logic [11:0] o);
        rd_reg(8'h10 + 8'(2 * n), v);
        o[11:8] = v[3:0];
        rd_reg(8'h11 + 8'(2 * n), v);
        o[7:0] = v;
    endtask
    // bounded so a stuck sequence still reaches the flag checks
    task automatic wait_idle();
        #1;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic new_lvls();
        foreach (lvl[i]) lvl[i] <= 12'(xs());
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        stop_mode = 1'b0;
        freeze_mode = 1'b0;
        foreach (lvl[i]) lvl[i] = 12'h000;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        rd_reg(8'h0a, v);
        chk("flags", 12'h000, v);
        rd_reg(8'h40, v);
        chk("unmapped", 12'h000, v);
        // freeze with continue selected must not disturb these runs
        freeze_mode <= 1'b1;
        for (int res = 0; res < 3; res++) begin
            new_lvls();
            c = 3'(xs());
            wr_reg(8'h02, 8'(res));
            wr_reg(8'h05, {3'h0, c, 2'b00});
            #1 chk("mux", c, mux_sel);
            chk("sample", 1, sample_en);
            chk("busy", 1, busy);
            wait_idle();
            rd_res(0, r);
            chk("result", quant(lvl[c], 2'(res)), r);
            rd_reg(8'h0a, v);
            chk("flags", 12'h001, v);
            chk("power", 0, sar_power_en);
        end
        freeze_mode <= 1'b0;
        new_lvls();
        wr_reg(8'h02, 8'h02);
        wr_reg(8'h03, 8'h03);
        wr_reg(8'h05, 8'h1a);
        wait_idle();
        rd_reg(8'h0a, v);
        chk("flags", 12'h00f, v);
        for (int n = 0; n < 4; n++) begin
            rd_res(n, r);
            chk("result", lvl[3'(6 + n)], r);
        end
        wr_reg(8'h0a, 8'h02);
        wr_reg(8'h0a, 8'h00);
        rd_reg(8'h0a, v);
        chk("flags", 12'h00d, v);
        wr_reg(8'h05, 8'h1a);
        rd_reg(8'h0a, v);
        chk("flags", 12'h000, v);
        wait_idle();
        wr_reg(8'h02, 8'h06);
        rd_res(2, r);
        rd_reg(8'h0a, v);
        chk("flags", 12'h00b, v);
        // compare: equal value is the false boundary, one above is true
        wr_reg(8'h08, 8'h01);
        wr_reg(8'h09, 8'h01);
        wr_reg(8'h02, 8'h0e);
        wr_reg(8'h03, 8'h00);
        for (int k = 0; k < 2; k++) begin
            q = {1'b0, 11'(xs())};
            lvl[0] <= q + 12'(k);
            wr_reg(8'h10, {4'h0, q[11:8]});
            wr_reg(8'h11, q[7:0]);
            wr_reg(8'h05, 8'h00);
            wait_idle();
            rd_reg(8'h0a, v);
            chk("flags", 12'(k), v);
            chk("irq", 12'(k), cmp_irq);
            rd_res(0, r);
            chk("cmpval", q, r);
        end
        wr_reg(8'h11, q[7:0]);
        rd_reg(8'h0a, v);
        chk("flags", 12'h000, v);
        chk("irq", 0, cmp_irq);
        wr_reg(8'h08, 8'h00);
        wr_reg(8'h02, 8'h02);
        wr_reg(8'h03, 8'h02);
        new_lvls();
        // software side: only single runs are left going into a low-power mode
        wr_reg(8'h05, 8'h02);
        repeat (24) @(posedge sys_clk);
        stop_mode <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk("sample", 0, sample_en);
        chk("power", 0, sar_power_en);
        chk("busy", 0, busy);
        rd_reg(8'h06, v);
        chk("status", 12'h006, v);
        new_lvls();
        @(posedge sys_clk);
        stop_mode <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd_reg(8'h0a, v);
        chk("flags", 12'h000, v);
        wait_idle();
        rd_reg(8'h0a, v);
        chk("flags", 12'h007, v);
        rd_res(0, r);
        chk("result", lvl[0], r);
        wr_reg(8'h02, 8'h22);
        wr_reg(8'h03, 8'h00);
        wr_reg(8'h05, 8'h00);
        repeat (8) @(posedge sys_clk);
        freeze_mode <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 r = dac_code;
        repeat (20) @(posedge sys_clk);
        #1 chk("frozen", r, dac_code);
        chk("power", 1, sar_power_en);
        @(posedge sys_clk);
        freeze_mode <= 1'b0;
        wait_idle();
        rd_res(0, r);
        chk("result", lvl[0], r);
        tally_and_finish();
    end
endmodule
